// File: design/tfq_core.sv
// Purpose: Correct and filter the external diode reading, format and limit-check both channels
// Assumes: Converter delivers one measurement per meas_valid pulse
// Notes: Alert and overtemperature pins are open drain, oe high means pulled low
`timescale 1ns/1ps

module tfq_core
   import tfq_pkg::*;
#(
   parameter logic [5:0] IDEAL_NOM_CODE = 6'h12,
   parameter int RES_CORR_MAX = TFQ_RES_CORR_MAX_Q3
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic meas_valid,
   input wire logic signed [15:0] int_raw,
   input wire logic signed [15:0] ext_raw,
   input wire logic [9:0] res_err,
   input wire logic diode_open,
   input wire logic pos_short_vdd,
   input wire logic neg_short_vdd,
   input wire logic range_ext,
   input wire logic [1:0] filt_sel,
   input wire logic [5:0] ideality_code,
   input wire logic [10:0] high_lim_int,
   input wire logic [10:0] high_lim_ext,
   input wire logic [10:0] low_lim_int,
   input wire logic [10:0] low_lim_ext,
   input wire logic [10:0] therm_lim_int,
   input wire logic [10:0] therm_lim_ext,
   input wire logic [7:0] therm_hyst,
   input wire logic [2:0] alert_thr,
   input wire logic [2:0] therm_thr,
   input wire logic mask_all,
   input wire logic [1:0] ch_mask,
   input wire logic status_clr,
   output logic [7:0] int_hi_r,
   output logic [7:0] int_lo_r,
   output logic [7:0] ext_hi_r,
   output logic [7:0] ext_lo_r,
   output logic result_valid_r,
   output logic [1:0] high_stat_r,
   output logic [1:0] low_stat_r,
   output logic fault_stat_r,
   output logic [1:0] therm_stat_r,
   output logic alert_oe,
   output logic therm_oe
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Stored bytes keep the range they were taken in; limits must follow the range bit
   function automatic logic [10:0] fmt_code(input logic signed [15:0] t, input logic ext);
      logic signed [15:0] v;
      logic [10:0] top;
      v = ext ? t + TFQ_EXT_OFFSET_Q3 : t;
      top = ext ? TFQ_MAX_EXT : TFQ_MAX_DEF;
      if (v < 16'sh0000) begin
         fmt_code = TFQ_ZERO_CODE;
      end else if (v > $signed({5'h00, top})) begin
         fmt_code = top;
      end else begin
         fmt_code = v[10:0];
      end
   endfunction

   // Saturate instead of wrapping so a long excursion never restarts the count
   function automatic logic [TFQ_CNT_W-1:0] cnt_step(input logic [TFQ_CNT_W-1:0] c,
                                                      input logic bad);
      if (!bad) begin
         cnt_step = '0;
      end else if (c == {TFQ_CNT_W{1'b1}}) begin
         cnt_step = c;
      end else begin
         cnt_step = c + 4'h1;
      end
   endfunction

   // Hysteresis is in whole degrees, scaled by eight to meet the code
   function automatic logic below_release(input logic [10:0] code, input logic [10:0] lim,
                                          input logic [7:0] hyst);
      logic signed [12:0] edge_v;
      edge_v = $signed({2'b00, lim}) - $signed({2'b00, hyst, 3'b000});
      below_release = $signed({2'b00, code}) < edge_v;
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic signed [15:0] filt_r, filt_nxt;
   logic filt_primed_r, filt_primed_nxt;
   logic [7:0] int_hi_nxt, int_lo_nxt, ext_hi_nxt, ext_lo_nxt;
   logic result_valid_nxt;
   logic [TFQ_CNT_W-1:0] a_cnt_r [2];
   logic [TFQ_CNT_W-1:0] a_cnt_nxt [2];
   logic [TFQ_CNT_W-1:0] t_cnt_r [2];
   logic [TFQ_CNT_W-1:0] t_cnt_nxt [2];
   logic [1:0] high_stat_nxt, low_stat_nxt, therm_stat_nxt;
   logic fault_stat_nxt;
   logic alert_r, alert_nxt, therm_r, therm_nxt;

   // ----------------------------------------
   // Measurement datapath
   // ----------------------------------------
   logic fault;
   logic signed [15:0] res_sub, ext_rc, ext_kel, ext_ic, ext_f, int_use;
   logic signed [6:0] ideal_diff;
   logic signed [23:0] ideal_prod;
   logic [10:0] code [2];
   logic [10:0] hlim [2];
   logic [10:0] llim [2];
   logic [10:0] tlim [2];
   logic [1:0] is_high, is_low, is_over, is_below;
   logic [TFQ_CNT_W-1:0] a_need, t_need;
   logic [1:0] a_qual, t_qual;

   // Neg-pin-to-ground short is not listed, so it measures normally
   assign fault = diode_open | pos_short_vdd | neg_short_vdd;

   always_comb begin
      // Clamp the estimate so a broken estimate cannot swing past the corrected span
      if (res_err > 10'(RES_CORR_MAX)) begin
         res_sub = 16'(RES_CORR_MAX);
      end else begin
         res_sub = $signed({6'h00, res_err});
      end
      ext_rc = ext_raw - res_sub;
      ideal_diff = $signed({1'b0, ideality_code}) - $signed({1'b0, IDEAL_NOM_CODE});
      ext_kel = ext_rc + TFQ_KELVIN_Q3;
      ideal_prod = ext_kel * ideal_diff;
      ext_ic = ext_rc - 16'(ideal_prod >>> TFQ_IDEAL_SHIFT);
      // First sample seeds the filter so it does not ramp up from zero
      if (!filt_primed_r) begin
         ext_f = ext_ic;
      end else begin
         unique case (filt_sel)
            TFQ_FILT_L1: ext_f = 16'((17'(filt_r) + 17'(ext_ic)) >>> 1);
            TFQ_FILT_L2: ext_f = 16'((18'(filt_r) * 18'sd3 + 18'(ext_ic)) >>> 2);
            default: ext_f = ext_ic;
         endcase
      end
      // Internal channel has no diode, so it skips correction and filter
      int_use = int_raw;
      code[TFQ_CH_INT] = fmt_code(int_use, range_ext);
      code[TFQ_CH_EXT] = fault ? TFQ_ZERO_CODE : fmt_code(ext_f, range_ext);
   end

   always_comb begin
      hlim[TFQ_CH_INT] = high_lim_int;
      hlim[TFQ_CH_EXT] = high_lim_ext;
      llim[TFQ_CH_INT] = low_lim_int;
      llim[TFQ_CH_EXT] = low_lim_ext;
      tlim[TFQ_CH_INT] = therm_lim_int;
      tlim[TFQ_CH_EXT] = therm_lim_ext;
      for (int c = 0; c < 2; c++) begin
         is_high[c] = code[c] > hlim[c];
         is_low[c] = code[c] < llim[c];
         is_over[c] = code[c] >= tlim[c];
         is_below[c] = below_release(code[c], tlim[c], therm_hyst);
      end
      is_low[TFQ_CH_EXT] = is_low[TFQ_CH_EXT] & ~fault;
      // A broken diode counts as hot, so a fault cannot hide an overtemperature
      is_over[TFQ_CH_EXT] = is_over[TFQ_CH_EXT] | fault;
      // Release also waits for a fault-free reading
      is_below[TFQ_CH_EXT] = is_below[TFQ_CH_EXT] & ~fault;
   end

   // ----------------------------------------
   // Result and filter registers
   // ----------------------------------------
   always_comb begin
      filt_nxt = filt_r;
      filt_primed_nxt = filt_primed_r;
      int_hi_nxt = int_hi_r;
      int_lo_nxt = int_lo_r;
      ext_hi_nxt = ext_hi_r;
      ext_lo_nxt = ext_lo_r;
      // Valid flag is a one-cycle echo of the measurement strobe
      result_valid_nxt = meas_valid;
      if (meas_valid) begin
         // A faulted sample must not pollute the filter history
         if (!fault) begin
            filt_nxt = ext_f;
            filt_primed_nxt = 1'b1;
         end
         int_hi_nxt = code[TFQ_CH_INT][10:3];
         int_lo_nxt = {code[TFQ_CH_INT][2:0], 5'h00};
         ext_hi_nxt = fault ? TFQ_FAULT_BYTE : code[TFQ_CH_EXT][10:3];
         ext_lo_nxt = fault ? TFQ_FAULT_BYTE : {code[TFQ_CH_EXT][2:0], 5'h00};
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         filt_r <= '0;
         filt_primed_r <= 1'b0;
         int_hi_r <= '0;
         int_lo_r <= '0;
         ext_hi_r <= '0;
         ext_lo_r <= '0;
         result_valid_r <= 1'b0;
      end else begin
         filt_r <= filt_nxt;
         filt_primed_r <= filt_primed_nxt;
         int_hi_r <= int_hi_nxt;
         int_lo_r <= int_lo_nxt;
         ext_hi_r <= ext_hi_nxt;
         ext_lo_r <= ext_lo_nxt;
         result_valid_r <= result_valid_nxt;
      end
   end

   // ----------------------------------------
   // Consecutive qualification and pins
   // ----------------------------------------
   // Threshold fields hold the count minus one, so zero means a single reading
   assign a_need = {1'b0, alert_thr} + 4'h1;
   assign t_need = {1'b0, therm_thr} + 4'h1;

   always_comb begin
      a_qual = '0;
      t_qual = '0;
      for (int c = 0; c < 2; c++) begin
         a_cnt_nxt[c] = a_cnt_r[c];
         t_cnt_nxt[c] = t_cnt_r[c];
         if (meas_valid) begin
            a_cnt_nxt[c] = cnt_step(a_cnt_r[c], is_high[c] | is_low[c] |
                                    ((c == TFQ_CH_EXT) & fault));
            t_cnt_nxt[c] = cnt_step(t_cnt_r[c], is_over[c]);
            a_qual[c] = a_cnt_nxt[c] >= a_need;
            t_qual[c] = t_cnt_nxt[c] >= t_need;
         end
      end
      // Set beats clear when both land in one cycle
      high_stat_nxt = (status_clr ? 2'b00 : high_stat_r) | (a_qual & is_high);
      low_stat_nxt = (status_clr ? 2'b00 : low_stat_r) | (a_qual & is_low);
      fault_stat_nxt = (status_clr ? 1'b0 : fault_stat_r) |
                       (a_qual[TFQ_CH_EXT] & meas_valid & fault);
      // Mask_all hides the pin only; status keeps updating underneath
      alert_nxt = !mask_all &&
                  (|((high_stat_nxt | low_stat_nxt) & ~ch_mask) ||
                   (fault_stat_nxt && !ch_mask[TFQ_CH_EXT]));
      therm_nxt = therm_r;
      if (|t_qual) begin
         therm_nxt = 1'b1;
      end else if (meas_valid && therm_r && (&is_below)) begin
         therm_nxt = 1'b0;
      end
      therm_stat_nxt = therm_nxt ? (therm_stat_r | t_qual) : 2'b00;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         a_cnt_r[0] <= '0;
         a_cnt_r[1] <= '0;
         t_cnt_r[0] <= '0;
         t_cnt_r[1] <= '0;
         high_stat_r <= '0;
         low_stat_r <= '0;
         fault_stat_r <= 1'b0;
         therm_stat_r <= '0;
         alert_r <= 1'b0;
         therm_r <= 1'b0;
      end else begin
         a_cnt_r <= a_cnt_nxt;
         t_cnt_r <= t_cnt_nxt;
         high_stat_r <= high_stat_nxt;
         low_stat_r <= low_stat_nxt;
         fault_stat_r <= fault_stat_nxt;
         therm_stat_r <= therm_stat_nxt;
         alert_r <= alert_nxt;
         therm_r <= therm_nxt;
      end
   end

   // Pins are open drain: oe high pulls the line low
   assign alert_oe = alert_r;
   assign therm_oe = therm_r;

endmodule

// File: design/tfq_pkg.sv
// Purpose: Shared constants for the temperature result and fault qualifier
// Assumes: Temperatures travel as signed fixed point, 1/8 degree per count
// Notes: Channel 0 is the internal sensor, channel 1 the external diode
package tfq_pkg;

   // ----------------------------------------
   // Widths and channels
   // ----------------------------------------
   localparam int TFQ_CODE_W = 11;
   localparam int TFQ_WORK_W = 16;
   localparam int TFQ_CH_INT = 0;
   localparam int TFQ_CH_EXT = 1;

   // ----------------------------------------
   // Result formats
   // ----------------------------------------
   localparam logic signed [15:0] TFQ_EXT_OFFSET_Q3 = 16'sh0200;
   localparam logic [10:0] TFQ_MAX_DEF = 11'h3ff;
   localparam logic [10:0] TFQ_MAX_EXT = 11'h7ff;
   localparam logic [10:0] TFQ_ZERO_CODE = 11'h000;
   localparam logic [7:0] TFQ_FAULT_BYTE = 8'h00;
   localparam int TFQ_LO_BYTE_POS = 5;

   // ----------------------------------------
   // Correction terms
   // ----------------------------------------
   localparam logic signed [15:0] TFQ_KELVIN_Q3 = 16'sh0888;
   localparam int TFQ_RES_MAX_OHM = 100;
   localparam int TFQ_ERR_PER_OHM_MDEG = 700;
   localparam int TFQ_RES_CORR_MAX_Q3 = TFQ_RES_MAX_OHM * TFQ_ERR_PER_OHM_MDEG * 8 / 1000;
   localparam int TFQ_IDEAL_SHIFT = 11;

   // ----------------------------------------
   // Filter settings
   // ----------------------------------------
   localparam logic [1:0] TFQ_FILT_OFF = 2'h0;
   localparam logic [1:0] TFQ_FILT_L1 = 2'h1;
   localparam logic [1:0] TFQ_FILT_L2 = 2'h2;

   // ----------------------------------------
   // Consecutive counters
   // ----------------------------------------
   localparam int TFQ_CNT_W = 4;

endpackage

// File: tb/tb_temp_result_fault_qualify.sv
// Purpose: Self-checking bench for tfq_core
// Assumes: Inputs change on the falling edge
// Notes: Result codes are rebuilt from the two bytes
`timescale 1ns/1ps
module tb_temp_result_fault_qualify;
   import tfq_pkg::*;
   logic core_clk, srst, meas_valid, diode_open, pos_short_vdd, neg_short_vdd;
   logic signed [15:0] int_raw, ext_raw;
   logic range_ext, mask_all, status_clr;
   logic [1:0] filt_sel, ch_mask, high_stat_r, low_stat_r, therm_stat_r;
   logic [9:0] res_err;
   logic [10:0] hi_lim, lo_lim, th_lim;
   logic [7:0] therm_hyst, int_hi_r, int_lo_r, ext_hi_r, ext_lo_r;
   logic [2:0] alert_thr, therm_thr;
   logic result_valid_r, fault_stat_r, alert_oe, therm_oe;
   int mismatches, check_count;
   int tv[8] = '{-520, -8, 0, 1, 512, 1023, 1024, 1536};
   int tt[6] = '{450, 450, 100, 450, 450, 450};
   tfq_front front (.core_clk(core_clk), .meas_valid(meas_valid), .int_raw(int_raw),
      .ext_raw(ext_raw), .diode_open(diode_open), .pos_short_vdd(pos_short_vdd),
      .neg_short_vdd(neg_short_vdd));
   tfq_core uut (.core_clk(core_clk), .srst(srst), .meas_valid(meas_valid),
      .int_raw(int_raw), .ext_raw(ext_raw), .res_err(res_err), .diode_open(diode_open),
      .pos_short_vdd(pos_short_vdd), .neg_short_vdd(neg_short_vdd), .range_ext(range_ext),
      .filt_sel(filt_sel), .ideality_code(6'h12), .high_lim_int(hi_lim),
      .high_lim_ext(hi_lim), .low_lim_int(lo_lim), .low_lim_ext(lo_lim),
      .therm_lim_int(th_lim), .therm_lim_ext(th_lim), .therm_hyst(therm_hyst),
      .alert_thr(alert_thr), .therm_thr(therm_thr), .mask_all(mask_all), .ch_mask(ch_mask),
      .status_clr(status_clr), .int_hi_r(int_hi_r), .int_lo_r(int_lo_r), .ext_hi_r(ext_hi_r),
      .ext_lo_r(ext_lo_r), .result_valid_r(result_valid_r), .high_stat_r(high_stat_r),
      .low_stat_r(low_stat_r), .fault_stat_r(fault_stat_r), .therm_stat_r(therm_stat_r),
      .alert_oe(alert_oe), .therm_oe(therm_oe));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [10:0] fmt(input int t, input logic ext);
      int v;
      v = t + (ext ? 512 : 0);
      if (v < 0) v = 0;
      if (v > (ext ? 2047 : 1023)) v = ext ? 2047 : 1023;
      return v[10:0];
   endfunction
   function automatic logic [10:0] ecode();
      return {ext_hi_r, ext_lo_r[7:5]};
   endfunction
   task automatic clr();
      status_clr = 1'b1;
      @(negedge core_clk);
      status_clr = 1'b0;
      @(negedge core_clk);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      #20000;
      mismatches++;
      print_verdict();
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {srst, range_ext, mask_all, status_clr} = 4'h8;
      {filt_sel, alert_thr, therm_thr, therm_hyst} = {2'h0, 3'h0, 3'h7, 8'h02};
      {ch_mask, res_err} = 12'h000;
      {hi_lim, lo_lim, th_lim} = {11'h7ff, 11'h000, 11'h7ff};
      repeat (12) @(negedge core_clk);
      srst = 1'b0;
      chk({alert_oe, therm_oe, result_valid_r, ext_hi_r}, 11'h000);
      for (int r = 0; r < 2; r++) begin
         range_ext = r[0];
         foreach (tv[i]) begin
            front.measure(tv[i], tv[i], 2'h0);
            chk({10'h000, result_valid_r}, 11'h001);
            chk({int_hi_r, int_lo_r[7:5]}, fmt(tv[i], r[0]));
            chk(ecode(), fmt(tv[i], r[0]));
            chk({6'h00, ext_lo_r[4:0]}, 11'h000);
         end
      end
      range_ext = 1'b0;
      lo_lim = 11'h100;
      for (int f = 1; f < 4; f++) begin
         front.measure(600, 300, 2'(f));
         chk(ecode(), 11'h000);
         chk({8'h00, fault_stat_r, low_stat_r[1], alert_oe}, 11'h005);
      end
      mask_all = 1'b1;
      repeat (2) @(negedge core_clk);
      chk({10'h000, alert_oe}, 11'h000);
      mask_all = 1'b0;
      front.measure(600, 0, 2'h0);
      chk({9'h000, low_stat_r[1], alert_oe}, 11'h003);
      front.measure(600, 300, 2'h0);
      chk(ecode(), 11'd300);
      lo_lim = 11'h000;
      clr();
      chk({9'h000, low_stat_r[1], alert_oe}, 11'h000);
      hi_lim = 11'd500;
      front.measure(600, 100, 2'h0);
      chk({8'h00, high_stat_r, alert_oe}, 11'h003);
      ch_mask = 2'h1;
      @(negedge core_clk);
      chk({10'h000, alert_oe}, 11'h000);
      {ch_mask, hi_lim} = {2'h0, 11'h7ff};
      clr();
      {therm_thr, th_lim} = {3'h2, 11'd400};
      foreach (tt[i]) begin
         front.measure(tt[i], 100, 2'h0);
         chk({10'h000, therm_oe}, {10'h000, i == 5});
      end
      chk({8'h00, alert_oe, therm_stat_r}, 11'h001);
      front.measure(390, 100, 2'h0);
      chk({10'h000, therm_oe}, 11'h001);
      front.measure(380, 100, 2'h0);
      chk({8'h00, therm_oe, therm_stat_r}, 11'h000);
      srst = 1'b1;
      @(negedge core_clk);
      {srst, filt_sel} = 3'h1;
      chk({alert_oe, therm_oe, result_valid_r, ext_hi_r}, 11'h000);
      front.measure(100, 80, 2'h0);
      chk(ecode(), 11'd80);
      front.measure(100, 160, 2'h0);
      chk(ecode(), 11'd120);
      filt_sel = 2'h2;
      front.measure(100, 200, 2'h0);
      chk(ecode(), 11'd140);
      filt_sel = 2'h3;
      front.measure(100, 300, 2'h0);
      chk(ecode(), 11'd300);
      res_err = 10'd40;
      front.measure(100, 300, 2'h0);
      chk(ecode(), 11'd260);
      res_err = 10'd1000;
      front.measure(100, 900, 2'h0);
      chk(ecode(), 11'(900 - TFQ_RES_CORR_MAX_Q3));
      print_verdict();
   end
endmodule

// File: tb/tfq_core_monitor.sv
// Purpose: Port-level checks on the result and fault qualifier
// Assumes: Single clock, synchronous active-high reset
// Notes: Bound to tfq_core; watches design inputs and outputs only
`timescale 1ns/1ps
module tfq_core_monitor (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic meas_valid,
   input wire logic diode_open,
   input wire logic pos_short_vdd,
   input wire logic neg_short_vdd,
   input wire logic range_ext,
   input wire logic mask_all,
   input wire logic status_clr,
   input wire logic [7:0] int_hi_r,
   input wire logic [7:0] int_lo_r,
   input wire logic [7:0] ext_hi_r,
   input wire logic [7:0] ext_lo_r,
   input wire logic result_valid_r,
   input wire logic [1:0] low_stat_r,
   input wire logic [1:0] therm_stat_r,
   input wire logic alert_oe,
   input wire logic therm_oe
);
   logic flt;
   assign flt = diode_open | pos_short_vdd | neg_short_vdd;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   property p_valid; meas_valid |=> result_valid_r; endproperty
   a_valid: assert property (p_valid) else $error("no result after measurement");
   property p_lo; ##1 (ext_lo_r[4:0] == 5'h00) && (int_lo_r[4:0] == 5'h00); endproperty
   a_lo: assert property (p_lo) else $error("low byte spare bits set");
   property p_fz; meas_valid && flt |=> ext_hi_r == 8'h00 && ext_lo_r == 8'h00; endproperty
   a_fz: assert property (p_fz) else $error("fault result not zero");
   property p_fl; meas_valid && flt && !status_clr |=> $stable(low_stat_r[1]); endproperty
   a_fl: assert property (p_fl) else $error("low check on faulted sample");
   property p_dc; meas_valid && !range_ext |=> !ext_hi_r[7] && !int_hi_r[7]; endproperty
   a_dc: assert property (p_dc) else $error("default range above max code");
   property p_mask; mask_all [*2] |-> !alert_oe; endproperty
   a_mask: assert property (p_mask) else $error("alert active while masked");
   property p_th; therm_oe && !meas_valid |=> therm_oe; endproperty
   a_th: assert property (p_th) else $error("overtemp dropped without measurement");
   property p_tr; $rose(therm_oe) |-> result_valid_r; endproperty
   a_tr: assert property (p_tr) else $error("overtemp rose off a result");
   property p_ts; therm_stat_r != 2'h0 |-> therm_oe; endproperty
   a_ts: assert property (p_ts) else $error("overtemp status without pin");
   c_flt: cover property (meas_valid && flt);
   c_th: cover property ($rose(therm_oe));
   c_al: cover property ($rose(alert_oe));
endmodule
bind tfq_core tfq_core_monitor mon (
   .core_clk(core_clk),
   .srst(srst),
   .meas_valid(meas_valid),
   .diode_open(diode_open),
   .pos_short_vdd(pos_short_vdd),
   .neg_short_vdd(neg_short_vdd),
   .range_ext(range_ext),
   .mask_all(mask_all),
   .status_clr(status_clr),
   .int_hi_r(int_hi_r),
   .int_lo_r(int_lo_r),
   .ext_hi_r(ext_hi_r),
   .ext_lo_r(ext_lo_r),
   .result_valid_r(result_valid_r),
   .low_stat_r(low_stat_r),
   .therm_stat_r(therm_stat_r),
   .alert_oe(alert_oe),
   .therm_oe(therm_oe)
);

// File: tb/tfq_front.sv
// Purpose: Behavioural diode and converter front end
// Assumes: Bench calls measure once per sample
// Notes: flt 0 none or negative pin to ground, 1 open, 2/3 pin to supply
`timescale 1ns/1ps
module tfq_front (
   input wire logic core_clk,
   output logic meas_valid,
   output logic signed [15:0] int_raw,
   output logic signed [15:0] ext_raw,
   output logic diode_open,
   output logic pos_short_vdd,
   output logic neg_short_vdd
);
   initial begin
      meas_valid = 1'b0;
      int_raw = 16'sh0000;
      ext_raw = 16'sh0000;
      diode_open = 1'b0;
      pos_short_vdd = 1'b0;
      neg_short_vdd = 1'b0;
   end
   // Negative pin to ground with a diode present is just flt 0
   task automatic measure(input int ti, input int te, input logic [1:0] flt);
      @(negedge core_clk);
      meas_valid = 1'b1;
      int_raw = 16'(ti);
      ext_raw = 16'(te);
      diode_open = (flt == 2'h1);
      pos_short_vdd = (flt == 2'h2);
      neg_short_vdd = (flt == 2'h3);
      @(negedge core_clk);
      meas_valid = 1'b0;
      // Invert so a stale sample never looks valid
      int_raw = ~int_raw;
      ext_raw = ~ext_raw;
   endtask
endmodule
